// >>> mid_map.svh
`ifndef MID_MAP_SVH
`define MID_MAP_SVH

// ----------------------------------------
// Instruction word layout
// ----------------------------------------
`define MID_INSTR_W 14
`define MID_ADDR_MSB 6
`define MID_LIT_MSB 7
`define MID_DEST_BIT 7

// ----------------------------------------
// Opcode fields
// ----------------------------------------
`define MID_LIT_OPC 4'hC
`define MID_LIT_OPC_LSB 10
`define MID_COPY_OPC 6'h08
`define MID_COPY_OPC_LSB 8
`define MID_STORE_OPC 7'h01
`define MID_IDLE_OPC 7'h00
`define MID_SHORT_OPC_LSB 7
`define MID_IDLE_LOW 5'h00
`define MID_IDLE_LOW_MSB 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MID_ACC_RST 8'h00
`define MID_ZERO_RST 1'b0
`define MID_ADDR_RST 7'h00
`define MID_DATA_RST 8'h00
`define MID_INSTR_RST 14'h0000

`endif

// >>> mid_pkg.sv
`include "mid_map.svh"

package mid_pkg;

	// ----------------------------------------
	// Instruction cycle phases
	// ----------------------------------------
	typedef enum logic [3:0]
	{
		MID_Q1 = 4'h1,
		MID_Q2 = 4'h2,
		MID_Q3 = 4'h4,
		MID_Q4 = 4'h8
	} mid_phase_t;

	// ----------------------------------------
	// Decoded operations
	// ----------------------------------------
	typedef enum logic [4:0]
	{
		MID_OP_OTHER = 5'h01,
		MID_OP_IDLE = 5'h02,
		MID_OP_LOAD_LIT = 5'h04,
		MID_OP_COPY = 5'h08,
		MID_OP_STORE = 5'h10
	} mid_op_t;

	// ----------------------------------------
	// Register file write port
	// ----------------------------------------
	typedef struct packed
	{
		logic en;
		logic [`MID_ADDR_MSB:0] addr;
		logic [7:0] data;
	} mid_rf_wr_t;

endpackage

// >>> mid_phase_seq.sv
`include "mid_map.svh"

module mid_phase_seq
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	output mid_pkg::mid_phase_t phase_out
);
	import mid_pkg::*;

	mid_phase_t phase_d;

	// ----------------------------------------
	// Four-phase rotation, one clock per phase
	// ----------------------------------------
	always_comb
	begin
		case (phase_out)
			MID_Q1: phase_d = MID_Q2;
			MID_Q2: phase_d = MID_Q3;
			MID_Q3: phase_d = MID_Q4;
			MID_Q4: phase_d = MID_Q1;
			default: phase_d = MID_Q1;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			phase_out <= MID_Q1;
		else
			phase_out <= phase_d;
	end

endmodule

// >>> mid_move_decode.sv
`include "mid_map.svh"

// Behaviour
// - An opcode of 11 00xx loads the low-byte literal into the accumulator, flags untouched.
// - The two don't-care bits of the literal-load opcode are ignored, either value accepted.
// - The literal load takes one instruction cycle: decode, read literal, process, write.
// - Opcode 00 1000 reads register f and writes it to the accumulator (d=0) or back (d=1).
// - The register copy updates the zero flag from the moved value for either destination.
module mid_move_decode
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [`MID_INSTR_W-1:0] instr_in,
	input wire logic [7:0] rf_rd_data_in,
	output mid_pkg::mid_phase_t phase_out,
	output logic [`MID_ADDR_MSB:0] rf_rd_addr_out,
	output mid_pkg::mid_rf_wr_t rf_wr_out,
	output logic [7:0] acc_out,
	output logic zero_out,
	output logic unsupported_out
);
	import mid_pkg::*;

	logic [`MID_INSTR_W-1:0] instr_q;
	mid_op_t op_q;
	mid_op_t op_d;
	logic [7:0] operand_q;
	logic [7:0] result_q;
	logic dest_reg_q;
	logic [7:0] acc_q;
	logic zero_q;
	logic phase_q1;
	logic phase_q2;
	logic phase_q3;
	logic phase_q4;
	logic [7:0] operand_d;
	logic wr_en_d;
	logic acc_write;
	logic [7:0] acc_d;
	logic zero_write;
	logic zero_d;

	// ----------------------------------------
	// Phase sequencer
	// ----------------------------------------
	mid_phase_seq u_phase
	(
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.phase_out(phase_out)
	);

	// ----------------------------------------
	// Phase strobes
	// ----------------------------------------
	assign phase_q1 = (phase_out == MID_Q1);
	assign phase_q2 = (phase_out == MID_Q2);
	assign phase_q3 = (phase_out == MID_Q3);
	assign phase_q4 = (phase_out == MID_Q4);

	// ----------------------------------------
	// Opcode decode
	// ----------------------------------------
	always_comb
	begin
		if (instr_in[`MID_INSTR_W-1:`MID_LIT_OPC_LSB] == `MID_LIT_OPC)
			op_d = MID_OP_LOAD_LIT;
		else if (instr_in[`MID_INSTR_W-1:`MID_COPY_OPC_LSB] == `MID_COPY_OPC)
			op_d = MID_OP_COPY;
		else if (instr_in[`MID_INSTR_W-1:`MID_SHORT_OPC_LSB] == `MID_STORE_OPC)
			op_d = MID_OP_STORE;
		else if (instr_in[`MID_INSTR_W-1:`MID_SHORT_OPC_LSB] == `MID_IDLE_OPC
			&& instr_in[`MID_IDLE_LOW_MSB:0] == `MID_IDLE_LOW)
			op_d = MID_OP_IDLE;
		else
			op_d = MID_OP_OTHER;
	end

	// ----------------------------------------
	// Q1: decode and address the register file
	// ----------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			instr_q <= `MID_INSTR_RST;
			op_q <= MID_OP_IDLE;
			dest_reg_q <= 1'b0;
		end
		else if (phase_q1)
		begin
			instr_q <= instr_in;
			op_q <= op_d;
			dest_reg_q <= instr_in[`MID_DEST_BIT];
		end
	end

	// Address held for the whole instruction cycle
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rf_rd_addr_out <= `MID_ADDR_RST;
		else if (phase_q1)
			rf_rd_addr_out <= instr_in[`MID_ADDR_MSB:0];
	end

	// Other instruction groups pass through as idle
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			unsupported_out <= 1'b0;
		else if (phase_q1)
			unsupported_out <= (op_d == MID_OP_OTHER);
	end

	// ----------------------------------------
	// Q2: read operand
	// ----------------------------------------
	// Store takes the accumulator as it stood in Q2
	always_comb
	begin
		case (op_q)
			MID_OP_LOAD_LIT: operand_d = instr_q[`MID_LIT_MSB:0];
			MID_OP_COPY: operand_d = rf_rd_data_in;
			MID_OP_STORE: operand_d = acc_q;
			default: operand_d = operand_q;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			operand_q <= `MID_DATA_RST;
		else if (phase_q2)
			operand_q <= operand_d;
	end

	// ----------------------------------------
	// Q3: process, raise register write for Q4
	// ----------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			result_q <= `MID_DATA_RST;
		else if (phase_q3)
			result_q <= operand_q;
	end

	// Only store and copy-back touch the register file
	always_comb
	begin
		case (op_q)
			MID_OP_STORE: wr_en_d = 1'b1;
			MID_OP_COPY: wr_en_d = dest_reg_q;
			default: wr_en_d = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rf_wr_out.en <= 1'b0;
			rf_wr_out.addr <= `MID_ADDR_RST;
			rf_wr_out.data <= `MID_DATA_RST;
		end
		else if (phase_q3)
		begin
			rf_wr_out.en <= wr_en_d;
			rf_wr_out.addr <= instr_q[`MID_ADDR_MSB:0];
			rf_wr_out.data <= operand_q;
		end
		else
			rf_wr_out.en <= 1'b0;
	end

	// ----------------------------------------
	// Q4: write accumulator and zero flag
	// ----------------------------------------
	// Store and idle leave the accumulator alone
	always_comb
	begin
		case (op_q)
			MID_OP_LOAD_LIT: acc_write = 1'b1;
			MID_OP_COPY: acc_write = !dest_reg_q;
			default: acc_write = 1'b0;
		endcase
		if (acc_write)
			acc_d = result_q;
		else
			acc_d = acc_q;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			acc_q <= `MID_ACC_RST;
		else if (phase_q4)
			acc_q <= acc_d;
	end

	// Copy back to the register still refreshes the flag
	always_comb
	begin
		zero_write = (op_q == MID_OP_COPY);
		if (zero_write)
			zero_d = (result_q == 8'h00);
		else
			zero_d = zero_q;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			zero_q <= `MID_ZERO_RST;
		else if (phase_q4)
			zero_q <= zero_d;
	end

	assign acc_out = acc_q;
	assign zero_out = zero_q;

endmodule

// >>> mid_move_decode_sva.sv
module mid_move_decode_chk
(
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [13:0] instr_in,
	input wire logic [7:0] rf_rd_data_in,
	input mid_pkg::mid_phase_t phase_out,
	input wire logic [6:0] rf_rd_addr_out,
	input mid_pkg::mid_rf_wr_t rf_wr_out,
	input wire logic [7:0] acc_out,
	input wire logic zero_out,
	input wire logic unsupported_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import mid_pkg::*;
	wire tk = rst_n_in && phase_out == MID_Q1;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_lit;
		tk && instr_in[13:10] == 4'hC |-> ##4 acc_out == $past(instr_in[7:0], 4) && $stable(zero_out);
	endproperty
	a_lit: assert property (p_lit) else $error("literal load wrong");
	property p_cp_acc;
		tk && instr_in[13:7] == 7'h10 |-> ##4 acc_out == $past(rf_rd_data_in, 3);
	endproperty
	a_cp_acc: assert property (p_cp_acc) else $error("copy to acc wrong");
	property p_cp_zero;
		tk && instr_in[13:8] == 6'h08 |-> ##4 zero_out == ($past(rf_rd_data_in, 3) == 8'h00);
	endproperty
	a_cp_zero: assert property (p_cp_zero) else $error("zero flag wrong");
	property p_cp_back;
		tk && instr_in[13:7] == 7'h11 |-> ##3
			rf_wr_out == {1'b1, $past(instr_in[6:0], 3), $past(rf_rd_data_in, 2)} ##1 $stable(acc_out);
	endproperty
	a_cp_back: assert property (p_cp_back) else $error("copy back wrong");
	property p_store;
		tk && instr_in[13:7] == 7'h01 |-> ##3
			rf_wr_out == {1'b1, $past(instr_in[6:0], 3), $past(acc_out, 2)} ##1 $stable(zero_out);
	endproperty
	a_store: assert property (p_store) else $error("store wrong");
	property p_idle;
		tk && instr_in[13:7] == 7'h00 && instr_in[4:0] == 5'h00 |-> ##3 !rf_wr_out.en
			##1 $stable(acc_out) && $stable(zero_out);
	endproperty
	a_idle: assert property (p_idle) else $error("idle changed state");
	property p_wr_q4;
		rf_wr_out.en |-> phase_out == MID_Q4 && $past(phase_out) == MID_Q3;
	endproperty
	a_wr_q4: assert property (p_wr_q4) else $error("write outside Q4");
	property p_rd_addr;
		tk |=> rf_rd_addr_out == $past(instr_in[6:0]);
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("read address wrong");
endmodule

bind mid_move_decode mid_move_decode_chk u_chk (.sys_clk_in, .rst_n_in, .instr_in,
	.rf_rd_data_in, .phase_out, .rf_rd_addr_out, .rf_wr_out, .acc_out, .zero_out,
	.unsupported_out);

// >>> testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mid_pkg::*;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [13:0] instr_in = 14'h0000;
	logic [7:0] rf_rd_data_in = 8'h00;
	mid_phase_t phase_out;
	logic [6:0] rf_rd_addr_out;
	mid_rf_wr_t rf_wr_out;
	logic [7:0] acc_out;
	logic zero_out;
	logic unsupported_out;
	logic [7:0] ea = 8'h00;
	logic ez = 1'b0;
	logic [31:0] x = 32'h0000_0055;
	int bad_count = 0;
	int check_count = 0;
	mid_move_decode u_dut (.sys_clk_in, .rst_n_in, .instr_in, .rf_rd_data_in, .phase_out,
		.rf_rd_addr_out, .rf_wr_out, .acc_out, .zero_out, .unsupported_out);
	always #10 sys_clk_in = ~sys_clk_in;
	function logic [31:0] rnd();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction
	function mid_rf_wr_t exp_wr(logic [13:0] w, logic [7:0] d, logic [7:0] a);
		return {w[13:7] == 7'h11 || w[13:7] == 7'h01, w[6:0], w[13:7] == 7'h01 ? a : d};
	endfunction
	function logic exp_uns(logic [13:0] w);
		return !(w[13:10] == 4'hC || w[13:8] == 6'h08 || w[13:7] == 7'h01 ||
			(w[13:7] == 7'h00 && w[4:0] == 5'h00));
	endfunction
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic step(logic [13:0] w, logic [7:0] d);
		mid_rf_wr_t e;
		instr_in <= w;
		rf_rd_data_in <= d;
		@(posedge sys_clk_in) #1;
		chk("acc", acc_out, ea);
		chk("zero", zero_out, ez);
		chk("rd_addr", rf_rd_addr_out, w[6:0]);
		chk("phase", phase_out, MID_Q2);
		repeat (2) @(posedge sys_clk_in);
		#1;
		e = exp_wr(w, d, ea);
		chk("wr_en", rf_wr_out.en, e.en);
		if (e.en)
			chk("wr", rf_wr_out, e);
		chk("unsupported", unsupported_out, exp_uns(w));
		if (w[13:10] == 4'hC)
			ea = w[7:0];
		if (w[13:7] == 7'h10)
			ea = d;
		if (w[13:8] == 6'h08)
			ez = d == 8'h00;
		@(posedge sys_clk_in);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		logic [31:0] r;
		logic [13:0] w;
		repeat (6) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		step(14'h305A, 8'h00);
		step(14'h3300, 8'h11);
		step(14'h0805, 8'h00);
		step(14'h0885, 8'hA5);
		step(14'h0085, 8'h3C);
		step(14'h0060, 8'hFF);
		step(14'h0000, 8'h00);
		step(14'h3A00, 8'h77);
		repeat (300)
		begin
			r = rnd();
			w = r[13:0];
			case (r[17:16])
				2'h0: w[13:10] = 4'hC;
				2'h1: w[13:8] = 6'h08;
				2'h2: w[13:7] = 7'h01;
				default: w = r[18] ? w & 14'h0060 : w;
			endcase
			step(w, r[20] ? r[31:24] : 8'h00);
		end
		step(14'h0000, 8'h00);
		report_and_stop();
	end
endmodule
